//--- common/dma_status_pkg.sv
// Purpose: Shared constants for the DMA retirement status and channel map block.
// Assumes: Channel index 0 stands for channel 1 of each controller.
// Notes:   Register offsets are byte addresses on the plain register port.
`default_nettype none

package dma_status_pkg;

  // Register byte offsets.
  localparam logic [7:0]  OFS_PERIPH_EN   = 8'h00;
  localparam logic [7:0]  OFS_USB_EN      = 8'h04;
  localparam logic [7:0]  OFS_USB_DIR     = 8'h08;
  localparam logic [7:0]  OFS_SER_MODE    = 8'h0C;
  localparam logic [7:0]  OFS_LAST_STATUS = 8'h10;
  localparam logic [7:0]  OFS_CHAN_MAP    = 8'h14;

  // Reset values of the writable registers.
  localparam logic [15:0] EN_RESET        = 16'h0000;
  localparam logic [15:0] USB_DIR_RESET   = 16'h0000;
  localparam logic [3:0]  SER_MODE_RESET  = 4'h0;
  localparam logic [15:0] STATUS_ZERO     = 16'h0000;
  localparam logic [31:0] RDATA_ZERO      = 32'h0000_0000;

  // Channel map of the peripheral unit: serial pairs on 0..7, parallel port on 8, 10, 11.
  localparam logic [15:0] PERIPH_USED     = 16'h0DFF;
  // Channels of the peripheral unit that move peripheral-to-memory.
  localparam logic [15:0] PERIPH_P2M      = 16'h0555;
  localparam logic [3:0]  SERIAL_LAST     = 4'h7;

  // Channel map of the USB unit: endpoint 0 out/in on 0/1, endpoints 1..11 on 2..12.
  localparam logic [15:0] USB_USED        = 16'h1FFF;
  localparam logic [15:0] USB_FIXED_P2M   = 16'h0001;
  localparam logic [15:0] USB_DIR_PROG    = 16'h1FFC;

  // Status bits kept per peripheral mode; all others read back as zero.
  localparam logic [15:0] UART_RX_KEEP    = 16'hFC0F;
  localparam logic [15:0] SPI_RX_KEEP     = 16'hF000;
  localparam logic [15:0] USB_KEEP        = 16'hFFFF;
  localparam logic [15:0] UART_RX_UNUSED  = 16'h03F0;
  localparam logic [15:0] SPI_RX_UNUSED   = 16'h0FFF;

endpackage

`default_nettype wire

//--- hw/status_word_shaper.sv
// Purpose: Shapes a raw peripheral status word into the descriptor status field.
// Assumes: The raw word comes from the peripheral that serves the channel.
// Notes:   Purely combinational; the caller registers the result.
`default_nettype none

module status_word_shaper (
  // Channel selection
  input  wire logic        is_usb,
  input  wire logic [3:0]  chan,
  input  wire logic [3:0]  serial_sync,
  // Status words
  input  wire logic [15:0] raw,
  output logic      [15:0] word
);

  logic        chan_used;
  logic        is_serial_rx;
  logic        port_sync;
  logic [15:0] keep;

  // Classify the channel from its fixed wiring.
  assign chan_used    = is_usb ? dma_status_pkg::USB_USED[chan]
                               : dma_status_pkg::PERIPH_USED[chan];
  assign is_serial_rx = !is_usb && (chan <= dma_status_pkg::SERIAL_LAST) && !chan[0];
  assign port_sync    = serial_sync[chan[2:1]];

  // Pick the mask; transmitters, the parallel port and unused channels give zero.
  assign keep = !chan_used   ? dma_status_pkg::STATUS_ZERO :
                is_usb       ? dma_status_pkg::USB_KEEP :
                !is_serial_rx ? dma_status_pkg::STATUS_ZERO :
                port_sync    ? dma_status_pkg::SPI_RX_KEEP :
                               dma_status_pkg::UART_RX_KEEP;
  assign word = raw & keep;

endmodule

`default_nettype wire

//--- hw/dma_status_channel_map.sv
// Purpose: Retirement status writer and fixed channel map for two sixteen-channel DMA units.
// Assumes: Inputs are synchronous to clk; retire strobes are one-cycle pulses.
// Notes:   Each unit writes its own descriptor status one cycle after the retire strobe.
//
// Local design decisions: the strobed register port and the register addresses.
`default_nettype none

// Function
// - On retirement each channel writes the 16-bit peripheral status word into the descriptor.
// - An async serial receiver reports matches in 15:12, gap timeouts in 11:10, errors in 3:0.
// - A sync serial receiver reports matches in 15:12 and zero in 11:0.
// - Unused status bits read zero, including all bits for serial transmit and the parallel port.
// - USB status bits 15:14 give the endpoint state and 13:12 are endpoint flags.
// - With USB bit 12 set, bits 11:0 carry the low setup command address bits.
// - With USB bit 12 clear, bits 11:0 carry configuration, interface and alternate info.
// - Each of the two units has sixteen channels, each wired to one fixed request source.
// - The first unit serves serial and parallel-port peripherals, the second USB endpoints.
// - First-unit channels 1-8 serve serial ports B, A, C, D as receiver then transmitter.
// - First-unit channels 9, 11 receive and 12 transmits for the parallel port; 10, 13-16 unused.
// - Second-unit channel 1 is endpoint 0 out to memory and channel 2 endpoint 0 in from memory.
// - Second-unit channels 3-13 carry endpoints 1-11 in either direction; 14-16 unused.
// - The serial and USB controllers supply each frame's status word, stored by the engine.
module dma_status_channel_map (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Peripheral unit request lines and transfer grants
  input  wire logic [15:0] periph_req,
  output logic      [15:0] periph_xfer,
  output logic      [15:0] periph_dir_p2m,
  // USB unit request lines and transfer grants
  input  wire logic [15:0] usb_req,
  output logic      [15:0] usb_xfer,
  output logic      [15:0] usb_dir_p2m,
  // Peripheral unit retirement
  input  wire logic        periph_retire,
  input  wire logic [3:0]  periph_retire_chan,
  input  wire logic [15:0] periph_status_raw,
  output logic             periph_stat_we,
  output logic      [3:0]  periph_stat_chan,
  output logic      [15:0] periph_stat_word,
  // USB unit retirement
  input  wire logic        usb_retire,
  input  wire logic [3:0]  usb_retire_chan,
  input  wire logic [15:0] usb_status_raw,
  output logic             usb_stat_we,
  output logic      [3:0]  usb_stat_chan,
  output logic      [15:0] usb_stat_word
);

  logic [15:0] periph_en_q;
  logic [15:0] usb_en_q;
  logic [15:0] usb_dir_q;
  logic [3:0]  ser_mode_q;
  logic [31:0] rdata_q;
  logic [15:0] periph_xfer_q;
  logic [15:0] usb_xfer_q;
  logic [15:0] periph_dir_q;
  logic [15:0] usb_dir_out_q;
  logic        periph_we_q;
  logic [3:0]  periph_chan_q;
  logic [15:0] periph_word_q;
  logic        usb_we_q;
  logic [3:0]  usb_chan_q;
  logic [15:0] usb_word_q;

  wire         wr_periph_en;
  wire         wr_usb_en;
  wire         wr_usb_dir;
  wire         wr_ser_mode;
  wire  [31:0] rd_mux;
  wire  [15:0] periph_word_d;
  wire  [15:0] usb_word_d;
  wire  [15:0] usb_dir_d;

  // Register write decode.
  assign wr_periph_en = reg_wr && (reg_addr == dma_status_pkg::OFS_PERIPH_EN);
  assign wr_usb_en    = reg_wr && (reg_addr == dma_status_pkg::OFS_USB_EN);
  assign wr_usb_dir   = reg_wr && (reg_addr == dma_status_pkg::OFS_USB_DIR);
  assign wr_ser_mode  = reg_wr && (reg_addr == dma_status_pkg::OFS_SER_MODE);

  // Read selection; unmapped offsets read as zero.
  assign rd_mux =
    (reg_addr == dma_status_pkg::OFS_PERIPH_EN)   ? {16'h0000, periph_en_q} :
    (reg_addr == dma_status_pkg::OFS_USB_EN)      ? {16'h0000, usb_en_q} :
    (reg_addr == dma_status_pkg::OFS_USB_DIR)     ? {16'h0000, usb_dir_q} :
    (reg_addr == dma_status_pkg::OFS_SER_MODE)    ? {28'h0000000, ser_mode_q} :
    (reg_addr == dma_status_pkg::OFS_LAST_STATUS) ? {usb_word_q, periph_word_q} :
    (reg_addr == dma_status_pkg::OFS_CHAN_MAP)    ? {dma_status_pkg::USB_USED,
                                                     dma_status_pkg::PERIPH_USED} :
                                                    dma_status_pkg::RDATA_ZERO;

  // Software configuration registers.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      periph_en_q <= dma_status_pkg::EN_RESET;
      usb_en_q    <= dma_status_pkg::EN_RESET;
      usb_dir_q   <= dma_status_pkg::USB_DIR_RESET;
      ser_mode_q  <= dma_status_pkg::SER_MODE_RESET;
    end else begin
      if (wr_periph_en) periph_en_q <= reg_wdata[15:0];
      if (wr_usb_en)    usb_en_q    <= reg_wdata[15:0];
      if (wr_usb_dir)   usb_dir_q   <= reg_wdata[15:0] & dma_status_pkg::USB_DIR_PROG;
      if (wr_ser_mode)  ser_mode_q  <= reg_wdata[3:0];
    end
  end

  // Read data stands only in the cycle after the read strobe.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) rdata_q <= dma_status_pkg::RDATA_ZERO;
    else       rdata_q <= reg_rd ? rd_mux : dma_status_pkg::RDATA_ZERO;
  end

  // Endpoint 0 directions are fixed; endpoints 1 to 11 follow software.
  assign usb_dir_d = dma_status_pkg::USB_FIXED_P2M | usb_dir_q;

  // Transfer gating: only wired, enabled channels pass their requests.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      periph_xfer_q <= dma_status_pkg::EN_RESET;
      usb_xfer_q    <= dma_status_pkg::EN_RESET;
      periph_dir_q  <= dma_status_pkg::USB_DIR_RESET;
      usb_dir_out_q <= dma_status_pkg::USB_DIR_RESET;
    end else begin
      periph_xfer_q <= periph_req & periph_en_q & dma_status_pkg::PERIPH_USED;
      usb_xfer_q    <= usb_req & usb_en_q & dma_status_pkg::USB_USED;
      periph_dir_q  <= dma_status_pkg::PERIPH_P2M;
      usb_dir_out_q <= usb_dir_d;
    end
  end

  // Status shaping for the peripheral unit.
  status_word_shaper u_periph_shaper (
    .is_usb      (1'b0),
    .chan        (periph_retire_chan),
    .serial_sync (ser_mode_q),
    .raw         (periph_status_raw),
    .word        (periph_word_d)
  );

  // Status shaping for the USB unit.
  status_word_shaper u_usb_shaper (
    .is_usb      (1'b1),
    .chan        (usb_retire_chan),
    .serial_sync (ser_mode_q),
    .raw         (usb_status_raw),
    .word        (usb_word_d)
  );

  // Descriptor status writes; the last word of each unit stays readable.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      periph_we_q   <= 1'b0;
      periph_chan_q <= 4'h0;
      periph_word_q <= dma_status_pkg::STATUS_ZERO;
      usb_we_q      <= 1'b0;
      usb_chan_q    <= 4'h0;
      usb_word_q    <= dma_status_pkg::STATUS_ZERO;
    end else begin
      periph_we_q <= periph_retire;
      usb_we_q    <= usb_retire;
      if (periph_retire) begin
        periph_chan_q <= periph_retire_chan;
        periph_word_q <= periph_word_d;
      end
      if (usb_retire) begin
        usb_chan_q <= usb_retire_chan;
        usb_word_q <= usb_word_d;
      end
    end
  end

  // Outputs come straight from flip-flops.
  assign reg_rdata        = rdata_q;
  assign periph_xfer      = periph_xfer_q;
  assign usb_xfer         = usb_xfer_q;
  assign periph_dir_p2m   = periph_dir_q;
  assign usb_dir_p2m      = usb_dir_out_q;
  assign periph_stat_we   = periph_we_q;
  assign periph_stat_chan = periph_chan_q;
  assign periph_stat_word = periph_word_q;
  assign usb_stat_we      = usb_we_q;
  assign usb_stat_chan    = usb_chan_q;
  assign usb_stat_word    = usb_word_q;

  // Retirement steps of each unit.
  sequence s_periph_retire;
    periph_retire ##1 periph_stat_we;
  endsequence

  sequence s_usb_retire;
    usb_retire ##1 usb_stat_we;
  endsequence

  property p_retire_write;
    @(posedge clk) disable iff (!rstn)
    s_periph_retire |-> periph_stat_chan == $past(periph_retire_chan);
  endproperty
  a_retire_write: assert property (p_retire_write)
    else $error("Peripheral retire did not write status for its channel.");

  property p_uart_rx;
    @(posedge clk) disable iff (!rstn)
    (periph_retire && periph_retire_chan <= 4'h7 && !periph_retire_chan[0]
     && !ser_mode_q[periph_retire_chan[2:1]])
    |=> periph_stat_word == ($past(periph_status_raw) & 16'hFC0F);
  endproperty
  a_uart_rx: assert property (p_uart_rx)
    else $error("Async receive status word wrong.");

  property p_spi_rx;
    @(posedge clk) disable iff (!rstn)
    (periph_retire && periph_retire_chan <= 4'h7 && !periph_retire_chan[0]
     && ser_mode_q[periph_retire_chan[2:1]])
    |=> periph_stat_word[11:0] == 12'h000
        && periph_stat_word[15:12] == $past(periph_status_raw[15:12]);
  endproperty
  a_spi_rx: assert property (p_spi_rx)
    else $error("Sync receive status word wrong.");

  property p_unused_zero;
    @(posedge clk) disable iff (!rstn)
    periph_stat_we && (periph_stat_chan[0] || periph_stat_chan > 4'h7)
    |-> periph_stat_word == 16'h0000;
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("Transmit or parallel-port status not zero.");

  property p_usb_word;
    @(posedge clk) disable iff (!rstn)
    s_usb_retire |-> (usb_stat_chan <= 4'hC) ? usb_stat_word == $past(usb_status_raw)
                                             : usb_stat_word == 16'h0000;
  endproperty
  a_usb_word: assert property (p_usb_word)
    else $error("USB status word not passed through.");

  property p_usb_setup_addr;
    @(posedge clk) disable iff (!rstn)
    (usb_retire && usb_retire_chan <= 4'hC && usb_status_raw[12])
    |=> usb_stat_word[12] && usb_stat_word[11:0] == $past(usb_status_raw[11:0]);
  endproperty
  a_usb_setup_addr: assert property (p_usb_setup_addr)
    else $error("Setup address bits lost.");

  property p_unused_quiet;
    @(posedge clk) disable iff (!rstn)
    (periph_xfer & 16'hF200) == 16'h0000 && (usb_xfer & 16'hE000) == 16'h0000;
  endproperty
  a_unused_quiet: assert property (p_unused_quiet)
    else $error("Unused channel asserted a transfer.");

  property p_grant;
    @(posedge clk) disable iff (!rstn)
    (periph_req[0] && periph_en_q[0] && !wr_periph_en) ##1 periph_req[0] |-> periph_xfer[0];
  endproperty
  a_grant: assert property (p_grant)
    else $error("Enabled channel request not granted.");

  property p_periph_dir;
    @(posedge clk) disable iff (!rstn)
    $past(rstn) |-> periph_dir_p2m == 16'h0555;
  endproperty
  a_periph_dir: assert property (p_periph_dir)
    else $error("Peripheral unit direction map wrong.");

  property p_usb_dir;
    @(posedge clk) disable iff (!rstn)
    wr_usb_dir ##2 1'b1 |-> usb_dir_p2m == ((($past(reg_wdata[15:0], 2)) & 16'h1FFC) | 16'h0001);
  endproperty
  a_usb_dir: assert property (p_usb_dir)
    else $error("USB direction not following software.");

endmodule

`default_nettype wire

//--- verif/periph_status_source.sv
// Purpose: Behavioural peripheral side: request lines and retirement status words.
// Assumes: The bench calls its tasks; every change lands just after a rising edge.
// Notes:   Released status lines show the inverse word so stale data never looks fresh.
`default_nettype none

module periph_status_source (
  // Clock
  input  wire logic        clk,
  // Request lines
  output var  logic [15:0] p_req,
  output var  logic [15:0] u_req,
  // Retirement of both units
  output var  logic        p_ret,
  output var  logic [3:0]  p_chan,
  output var  logic [15:0] p_raw,
  output var  logic        u_ret,
  output var  logic [3:0]  u_chan,
  output var  logic [15:0] u_raw
);
  timeunit 1ns;
  timeprecision 1ns;

  // Quiet lines at time zero.
  initial begin
    {p_req, u_req, p_ret, p_chan, p_raw} = '0;
    {u_ret, u_chan, u_raw} = '0;
  end

  // Drives the request lines of both units.
  task automatic set_req(input logic [15:0] p, input logic [15:0] u);
    @(posedge clk);
    p_req <= p;
    u_req <= u;
  endtask

  // Both peripherals hand over one frame status word for one pulse.
  task automatic retire(input logic [3:0] pc, input logic [15:0] pw,
                        input logic [3:0] uc, input logic [15:0] uw);
    @(posedge clk);
    {p_ret, p_chan, p_raw} <= {1'b1, pc, pw};
    {u_ret, u_chan, u_raw} <= {1'b1, uc, uw};
    @(posedge clk);
    {p_ret, p_raw} <= {1'b0, ~pw};
    {u_ret, u_raw} <= {1'b0, ~uw};
  endtask
endmodule

`default_nettype wire

//--- verif/dma_status_channel_map_tb.sv
// Purpose: Self-checking bench for the retirement status writer and channel map.
// Assumes: Expected values are queued by the drivers and popped by a negedge monitor.
// Notes:   Outputs are sampled at the falling edge, where they have settled.
`default_nettype none

module dma_status_channel_map_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, xmark = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata;
  wire logic [15:0] p_req, u_req, p_raw, u_raw, ps_word, us_word;
  wire logic [15:0] p_xfer, p_dir, u_xfer, u_dir;
  wire logic [3:0] p_chan, u_chan, ps_chan, us_chan;
  wire logic p_ret, u_ret, ps_we, us_we;
  logic [31:0] rq[$];
  logic [19:0] pq[$], uq[$];
  logic [63:0] xq[$];
  logic [15:0] en_p = 16'h0000, en_u = 16'h0000, dir_v = 16'h0000, lp, lu, w;
  logic [3:0] ser_mode = 4'h0;
  logic rd_pend = 1'b0, xf_pend = 1'b0;
  int num_errors = 0, cmp_count = 0;

  // Clock at 20 MHz.
  always #25 clk = ~clk;

  dma_status_channel_map u_dma_status_channel_map (.clk(clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .periph_req(p_req), .periph_xfer(p_xfer),
    .periph_dir_p2m(p_dir), .usb_req(u_req), .usb_xfer(u_xfer), .usb_dir_p2m(u_dir),
    .periph_retire(p_ret), .periph_retire_chan(p_chan), .periph_status_raw(p_raw),
    .periph_stat_we(ps_we), .periph_stat_chan(ps_chan), .periph_stat_word(ps_word),
    .usb_retire(u_ret), .usb_retire_chan(u_chan), .usb_status_raw(u_raw),
    .usb_stat_we(us_we), .usb_stat_chan(us_chan), .usb_stat_word(us_word));

  periph_status_source u_periph_status_source (.clk(clk), .p_req(p_req), .u_req(u_req),
    .p_ret(p_ret), .p_chan(p_chan), .p_raw(p_raw), .u_ret(u_ret), .u_chan(u_chan),
    .u_raw(u_raw));

  // Counts a comparison and reports a mismatch at once.
  task automatic tally(input logic ok, input string what);
    cmp_count++;
    if (!ok) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask

  task automatic check_rd(input logic [31:0] got, input logic [31:0] exp);
    tally(got === exp, $sformatf("read %h expected %h", got, exp));
  endtask

  task automatic check_stat(input logic [19:0] got, input logic [19:0] exp);
    tally(got === exp, $sformatf("status %h expected %h", got, exp));
  endtask

  task automatic check_map(input logic [63:0] got, input logic [63:0] exp);
    tally(got === exp, $sformatf("grant map %h expected %h", got, exp));
  endtask

  // Register port master: one-cycle strobes set just after a rising edge.
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    rq.push_back(exp);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask

  // Raises requests and notes the grants and directions one cycle later.
  task automatic drive_req(input logic [15:0] p, input logic [15:0] u);
    u_periph_status_source.set_req(p, u);
    xq.push_back({dir_v & 16'h1FFC | 16'h0001, 16'h0555, u & en_u & 16'h1FFF,
                  p & en_p & 16'h0DFF});
    xmark <= 1'b1;
    @(posedge clk);
    xmark <= 1'b0;
  endtask

  // Peripheral-unit status: only serial receivers keep bits, by their mode.
  function automatic logic [15:0] p_shape(input logic [3:0] c, input logic [15:0] r);
    if (c > 4'h7 || c[0])
      return 16'h0000;
    return r & (ser_mode[c[2:1]] ? 16'hF000 : 16'hFC0F);
  endfunction

  task automatic do_retire(input logic [3:0] c, input logic [15:0] pr, input logic [15:0] ur);
    lp = p_shape(c, pr);
    lu = (c > 4'hC) ? 16'h0000 : ur;
    pq.push_back({c, lp});
    uq.push_back({c, lu});
    u_periph_status_source.retire(c, pr, c, ur);
  endtask

  // Monitor pops the oldest note whenever a result appears.
  always @(negedge clk) begin
    if (rd_pend)
      check_rd(reg_rdata, rq.pop_front());
    if (xf_pend)
      check_map({u_dir, p_dir, u_xfer, p_xfer}, xq.pop_front());
    if (ps_we === 1'b1)
      check_stat({ps_chan, ps_word}, pq.pop_front());
    if (us_we === 1'b1)
      check_stat({us_chan, us_word}, uq.pop_front());
    rd_pend = reg_rd;
    xf_pend = xmark;
  end

  task automatic print_verdict();
    $display("Comparisons %0d, errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Watchdog against a hang.
  initial begin
    #(50 * 20000);
    num_errors++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    print_verdict();
  end

  initial begin
    void'($urandom(32'h620d));
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    // Reset values, fixed map, unmapped place and read-only writes.
    for (int a = 0; a < 5; a++)
      reg_read(8'(a * 4), 32'h0000_0000);
    reg_write(8'h14, 32'hFFFF_FFFF);
    reg_write(8'h10, 32'hFFFF_FFFF);
    reg_write(8'h18, 32'hFFFF_FFFF);
    reg_read(8'h14, 32'h1FFF_0DFF);
    reg_read(8'h10, 32'h0000_0000);
    reg_read(8'h18, 32'h0000_0000);
    // Disabled channels grant nothing; then all enabled, then random rounds.
    drive_req(16'hFFFF, 16'hFFFF);
    for (int i = 0; i < 8; i++) begin
      en_p = (i == 0) ? 16'hFFFF : 16'($urandom);
      en_u = (i == 0) ? 16'hFFFF : 16'($urandom);
      dir_v = 16'($urandom);
      reg_write(8'h00, {16'($urandom), en_p});
      reg_write(8'h04, {16'($urandom), en_u});
      reg_write(8'h08, {16'($urandom), dir_v});
      reg_read(8'h00, {16'h0000, en_p});
      reg_read(8'h08, {16'h0000, dir_v & 16'h1FFC});
      drive_req((i == 0) ? 16'hFFFF : 16'($urandom), (i == 0) ? 16'hFFFF : 16'($urandom));
    end
    // Every channel of both units retires under each serial mode set.
    for (int m = 0; m < 3; m++) begin
      ser_mode = (m == 0) ? 4'h0 : (m == 1) ? 4'hF : 4'($urandom);
      reg_write(8'h0C, {28'($urandom), ser_mode});
      reg_read(8'h0C, {28'h0, ser_mode});
      for (int c = 0; c < 16; c++) begin
        w = 16'($urandom);
        do_retire(4'(c), 16'($urandom), (m == 1) ? {w[15:13], 1'b1, 12'(w)} : w);
      end
    end
    do_retire(4'h0, 16'($urandom), 16'($urandom));
    reg_read(8'h10, {lu, lp});
    // Mid-run reset returns every register and output to its reset value.
    repeat (2) @(posedge clk);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    en_p = 16'h0000;
    en_u = 16'h0000;
    dir_v = 16'h0000;
    ser_mode = 4'h0;
    for (int a = 0; a < 5; a++)
      reg_read(8'(a * 4), 32'h0000_0000);
    drive_req(16'hFFFF, 16'hFFFF);
    for (int i = 0; i < 20 && (rq.size() + pq.size() + uq.size() + xq.size()) > 0; i++)
      @(posedge clk);
    if ((rq.size() + pq.size() + uq.size() + xq.size()) > 0) begin
      num_errors++;
      $display("CHECK FAILED at %0t: results never appeared", $time);
    end
    print_verdict();
  end
endmodule

`default_nettype wire
